// file: src/ulms_map.svh
// What this block does
// R1 - with the divisor access select bit set, offsets 0 and 1 reach the divisor low and high bytes.
// R2 - line status bit 0 is set while a received character waits in the buffer, clear otherwise.
// R3 - line status bits 1 to 4 report overrun, parity error, framing error and break.
// R4 - line status bit 5 is set while the transmit holding stage is empty.
// R5 - line status bit 6 is set only while holding stage and shift register are both empty.
// R6 - with FIFOs enabled, line status bit 7 is set while any buffered character has an error.
// R7 - modem status bits 0, 1 and 3 flag a change on clear-to-send, data-set-ready, carrier.
// R8 - modem status bit 2 is set on the trailing edge of the ring indicator.
// R9 - modem status bits 4 to 7 show clear-to-send, data-set-ready, ring and carrier now.
// R10 - offset 7 is a free byte scratch register with no effect on the port.
// R11 - modem control bit 0 drives terminal-ready and bit 1 drives request-to-send.
// R12 - reading modem status clears its change bits, reading line status clears bits 1 to 4.
`ifndef ULMS_MAP_SVH
`define ULMS_MAP_SVH
`define ULMS_OFS_DATA    3'h0
`define ULMS_OFS_IER     3'h1
`define ULMS_OFS_FCR     3'h2
`define ULMS_OFS_LCR     3'h3
`define ULMS_OFS_MODEM_CTRL   3'h4
`define ULMS_OFS_LINE_STATUS  3'h5
`define ULMS_OFS_MODEM_STATUS 3'h6
`define ULMS_OFS_SCR     3'h7
`define ULMS_BIT_DIV_SEL 7
`define ULMS_BIT_DTR     0
`define ULMS_BIT_RTS     1
`define ULMS_RST_BYTE    8'h00
`define ULMS_RST_NIBBLE  4'h0
`endif

// file: src/ulms_pkg.sv
package ulms_pkg;
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } ulms_rx_word_t;

    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ulms_modem_t;

    typedef struct packed {
        logic [7:0]                dll;
        logic [7:0]                dlm;
        logic [7:0]                ier;
        logic [7:0]                lcr;
        logic [7:0]                modem_ctrl;
        logic [7:0]                scr;
        logic [3:0]                line_err;
        logic [3:0]                modem_delta;
        ulms_modem_t               modem_prev;
        ulms_rx_word_t [1:0]       buf_mem;
        logic                      wr_ptr;
        logic                      rd_ptr;
        logic [1:0]                count;
        logic [7:0]                rd_data;
        logic [7:0]                tx_data;
        logic                      tx_load;
    } ulms_state_t;
endpackage : ulms_pkg

// file: src/ulms_top.sv
`timescale 1ns/100ps
`include "ulms_map.svh"
module ulms_top (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic [2:0]             addr,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    input  wire logic [7:0]             wr_data,
    output logic      [7:0]             rd_data,
    input  wire logic                   rx_valid,
    output logic                        rx_ready,
    input  wire ulms_pkg::ulms_rx_word_t rx_word,
    input  wire logic                   fifo_enable,
    input  wire logic                   tx_hold_empty,
    input  wire logic                   tx_shift_empty,
    output logic                        tx_load,
    output logic      [7:0]             tx_data,
    input  wire ulms_pkg::ulms_modem_t  modem_in,
    output logic                        dtr,
    output logic                        rts,
    output logic      [15:0]            divisor,
    output logic      [7:0]             line_ctrl,
    output logic      [7:0]             int_enable
);
    // ------------------------------------------------------------
    // state and views
    // ------------------------------------------------------------
    ulms_pkg::ulms_state_t st_reg;
    ulms_pkg::ulms_state_t st_next;
    logic                  div_sel;
    logic                  push;
    logic                  pop;
    logic [1:0]            entry_err;
    logic [7:0]            line_status;
    logic [7:0]            modem_status;
    logic [3:0]            modem_chg;

    assign div_sel  = st_reg.lcr[`ULMS_BIT_DIV_SEL];
    assign rx_ready = (st_reg.count != 2'h2);
    assign push     = ce && rx_valid && rx_ready;
    assign pop      = ce && rd_en && (addr == `ULMS_OFS_DATA) && !div_sel &&
                      (st_reg.count != 2'h0);

    // error summary per buffered entry
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_entry
            logic live;
            assign live = (st_reg.count == 2'h2) ||
                          ((st_reg.count == 2'h1) && (st_reg.rd_ptr == 1'(gi)));
            assign entry_err[gi] = live && (st_reg.buf_mem[gi].par ||
                                            st_reg.buf_mem[gi].frm ||
                                            st_reg.buf_mem[gi].brk);
        end
    endgenerate

    assign line_status  = {fifo_enable && (|entry_err),                // R6
                           tx_hold_empty && tx_shift_empty,            // R5
                           tx_hold_empty,                              // R4
                           st_reg.line_err,                            // R3
                           st_reg.count != 2'h0};                      // R2
    assign modem_status = {modem_in.dcd, modem_in.ri, modem_in.dsr, modem_in.cts, // R9
                           st_reg.modem_delta};

    // change detect: level change on cts, dsr, dcd; trailing edge on ring
    assign modem_chg = {modem_in.dcd ^ st_reg.modem_prev.dcd,           // R7
                        st_reg.modem_prev.ri && !modem_in.ri,           // R8
                        modem_in.dsr ^ st_reg.modem_prev.dsr,           // R7
                        modem_in.cts ^ st_reg.modem_prev.cts};          // R7

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next         = st_reg;
        st_next.tx_load = 1'b0;
        if (ce) begin
            st_next.modem_prev = modem_in;
            // register writes
            if (wr_en) begin
                case (addr)
                    `ULMS_OFS_DATA: begin
                        if (div_sel) begin
                            st_next.dll = wr_data;                      // R1
                        end else begin
                            st_next.tx_data = wr_data;
                            st_next.tx_load = 1'b1;
                        end
                    end
                    `ULMS_OFS_IER: begin
                        if (div_sel) begin
                            st_next.dlm = wr_data;                      // R1
                        end else begin
                            st_next.ier = wr_data;
                        end
                    end
                    `ULMS_OFS_LCR: st_next.lcr = wr_data;
                    `ULMS_OFS_MODEM_CTRL: st_next.modem_ctrl = wr_data; // R11
                    `ULMS_OFS_SCR: st_next.scr = wr_data;               // R10
                    default: ;
                endcase
            end
            // register reads, with their side effects
            if (rd_en) begin
                case (addr)
                    `ULMS_OFS_DATA: st_next.rd_data = div_sel ? st_reg.dll :          // R1
                                                      st_reg.buf_mem[st_reg.rd_ptr].data;
                    `ULMS_OFS_IER:  st_next.rd_data = div_sel ? st_reg.dlm : st_reg.ier; // R1
                    `ULMS_OFS_LCR:  st_next.rd_data = st_reg.lcr;
                    `ULMS_OFS_MODEM_CTRL: st_next.rd_data = st_reg.modem_ctrl;
                    `ULMS_OFS_LINE_STATUS: begin
                        st_next.rd_data  = line_status;
                        st_next.line_err = `ULMS_RST_NIBBLE;            // R12
                    end
                    `ULMS_OFS_MODEM_STATUS: begin
                        st_next.rd_data     = modem_status;
                        st_next.modem_delta = `ULMS_RST_NIBBLE;         // R12
                    end
                    `ULMS_OFS_SCR:  st_next.rd_data = st_reg.scr;       // R10
                    default:        st_next.rd_data = `ULMS_RST_BYTE;
                endcase
            end
            // set wins over the read clear
            st_next.modem_delta = st_next.modem_delta | modem_chg;      // R7 R8
            if (rx_valid && !rx_ready) begin
                st_next.line_err[0] = 1'b1;                             // R3
            end
            // two-entry receive buffer
            if (push) begin
                st_next.buf_mem[st_reg.wr_ptr] = rx_word;
                st_next.wr_ptr                 = !st_reg.wr_ptr;
                st_next.line_err[3:1]          = st_next.line_err[3:1] |
                                                 {rx_word.brk, rx_word.frm, rx_word.par}; // R3
            end
            if (pop) begin
                st_next.rd_ptr = !st_reg.rd_ptr;
            end
            case ({push, pop})
                2'b10:   st_next.count = st_reg.count + 2'h1;           // R2
                2'b01:   st_next.count = st_reg.count - 2'h1;           // R2
                default: st_next.count = st_reg.count;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data    = st_reg.rd_data;
    assign tx_load    = st_reg.tx_load;
    assign tx_data    = st_reg.tx_data;
    assign dtr        = st_reg.modem_ctrl[`ULMS_BIT_DTR];               // R11
    assign rts        = st_reg.modem_ctrl[`ULMS_BIT_RTS];               // R11
    assign divisor    = {st_reg.dlm, st_reg.dll};
    assign line_ctrl  = st_reg.lcr;
    assign int_enable = st_reg.ier;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_DIV_LOW_READ: assert property (@(posedge ref_clk) disable iff (rst) // R1
        (ce && rd_en && !wr_en && addr == `ULMS_OFS_DATA && div_sel) |=>
        (rd_data == $past(st_reg.dll) && $stable(st_reg.rd_ptr)))
        else $error("divisor low byte not returned at offset 0");

    AST_DATA_READY: assert property (@(posedge ref_clk) disable iff (rst) // R2
        (push && !pop && st_reg.count == 2'h0) |=> (line_status[0] && rx_ready))
        else $error("data ready not set after first character");

    AST_ERR_SET: assert property (@(posedge ref_clk) disable iff (rst) // R3
        (push && rx_word.par) |=> st_reg.line_err[1])
        else $error("parity error bit not set");

    AST_HOLD_EMPTY: assert property (@(posedge ref_clk) disable iff (rst) // R4
        (ce && rd_en && addr == `ULMS_OFS_LINE_STATUS) |=> (rd_data[5] == $past(tx_hold_empty)))
        else $error("holding empty bit wrong");

    AST_ALL_EMPTY: assert property (@(posedge ref_clk) disable iff (rst) // R5
        (ce && rd_en && addr == `ULMS_OFS_LINE_STATUS) |=>
        (rd_data[6] == ($past(tx_hold_empty) && $past(tx_shift_empty))))
        else $error("transmitter empty bit wrong");

    AST_FIFO_ERR: assert property (@(posedge ref_clk) disable iff (rst) // R6
        (ce && rd_en && addr == `ULMS_OFS_LINE_STATUS && !fifo_enable) |=> !rd_data[7])
        else $error("fifo error summary set with fifos off");

    AST_DELTA_CTS: assert property (@(posedge ref_clk) disable iff (rst) // R7
        (ce && modem_in.cts != st_reg.modem_prev.cts) |=> st_reg.modem_delta[0])
        else $error("cts change not flagged");

    AST_RING_TRAIL: assert property (@(posedge ref_clk) disable iff (rst) // R8
        (ce && !st_reg.modem_prev.ri && modem_in.ri &&
         !(rd_en && addr == `ULMS_OFS_MODEM_STATUS) && !st_reg.modem_delta[2]) |=>
        !st_reg.modem_delta[2])
        else $error("ring flag set on leading edge");

    AST_MODEM_LIVE: assert property (@(posedge ref_clk) disable iff (rst) // R9
        (ce && rd_en && addr == `ULMS_OFS_MODEM_STATUS) |=>
        (rd_data[7:4] == $past({modem_in.dcd, modem_in.ri, modem_in.dsr, modem_in.cts})))
        else $error("modem live bits wrong");

    AST_SCRATCH: assert property (@(posedge ref_clk) disable iff (rst) // R10
        (ce && wr_en && addr == `ULMS_OFS_SCR) ##1
        (ce && rd_en && !wr_en && addr == `ULMS_OFS_SCR) |=> (rd_data == $past(wr_data, 2)))
        else $error("scratch readback mismatch");

    AST_MODEM_OUT: assert property (@(posedge ref_clk) disable iff (rst) // R11
        (ce && wr_en && addr == `ULMS_OFS_MODEM_CTRL) |=>
        (dtr == $past(wr_data[0]) && rts == $past(wr_data[1])))
        else $error("modem control outputs do not follow write");

    AST_MODEM_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // R12
        (ce && rd_en && addr == `ULMS_OFS_MODEM_STATUS && modem_chg == 4'h0) |=>
        (st_reg.modem_delta == 4'h0))
        else $error("change bits not cleared by read");

    COV_BUF_FULL:  cover property (@(posedge ref_clk) disable iff (rst) !rx_ready ##1 pop);
    COV_OVERRUN:   cover property (@(posedge ref_clk) disable iff (rst) ce && rx_valid && !rx_ready);
    COV_DIV_WRITE: cover property (@(posedge ref_clk) disable iff (rst)
        ce && wr_en && div_sel && addr == `ULMS_OFS_IER);
    COV_RING:      cover property (@(posedge ref_clk) disable iff (rst) ce && modem_chg[2]);
endmodule : ulms_top

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic                    ref_clk, rst, wr_en, rd_en, rx_valid, rx_ready, fifo_enable, ce;
    logic                    tx_hold_empty, tx_shift_empty, tx_load, dtr, rts;
    logic [2:0]              addr;
    logic [7:0]              wr_data, rd_data, tx_data, line_ctrl, int_enable, v;
    logic [15:0]             divisor;
    ulms_pkg::ulms_rx_word_t rx_word;
    ulms_pkg::ulms_modem_t   modem_in;
    int                      n_fail, checked, cycles;
    ulms_top DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .fifo_enable(fifo_enable),
        .tx_hold_empty(tx_hold_empty), .tx_shift_empty(tx_shift_empty), .tx_load(tx_load),
        .tx_data(tx_data), .modem_in(modem_in), .dtr(dtr), .rts(rts), .divisor(divisor),
        .line_ctrl(line_ctrl), .int_enable(int_enable));
    ulms_far_model far (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx_word(rx_word), .modem_in(modem_in));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        #1;
    endtask : wr
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask : rd_chk
    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        chk({6'h00, dtr, rts}, 8'h00);
        wr(3'h4, 8'hA1);
        chk({6'h00, dtr, rts}, 8'h02);
        wr(3'h4, 8'h02);
        chk({6'h00, rts, dtr}, 8'h02);
        rd_chk(3'h4, 8'h02);
        wr(3'h7, 8'h5A);
        rd_chk(3'h7, 8'h5A);
        chk({6'h00, rts, dtr}, 8'h02);
        chk({7'h00, tx_load}, 8'h00);
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(3'h7, 8'hC4);
        @(posedge ref_clk);
        ce <= 1'b1;
        rd_chk(3'h7, 8'h5A);
    endtask : t_regs
    task automatic t_divisor();
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h34);
        chk({7'h00, tx_load}, 8'h00);
        wr(3'h1, 8'h12);
        chk(divisor[15:8], 8'h12);
        chk(divisor[7:0], 8'h34);
        chk(int_enable, 8'h00);
        wr(3'h3, 8'h03);
        chk(line_ctrl, 8'h03);
        wr(3'h0, 8'hC3);
        chk({7'h00, tx_load}, 8'h01);
        chk(tx_data, 8'hC3);
        chk(divisor[7:0], 8'h34);
    endtask : t_divisor
    task automatic t_rx_single();
        tx_hold_empty  <= 1'b1;
        tx_shift_empty <= 1'b0;
        far.push({1'b0, 1'b0, 1'b1, 8'h41});
        rd_chk(3'h5, 8'hA5);
        rd_chk(3'h5, 8'hA1);
        rd_chk(3'h0, 8'h41);
        rd_chk(3'h5, 8'h20);
    endtask : t_rx_single
    task automatic t_rx_overrun();
        tx_shift_empty <= 1'b1;
        far.push({1'b0, 1'b1, 1'b0, 8'h81});
        far.push({1'b1, 1'b0, 1'b0, 8'h7E});
        #1 chk({7'h00, rx_ready}, 8'h00);
        far.offer_once({1'b0, 1'b0, 1'b0, 8'hFF});
        rd_chk(3'h5, 8'hFB);
        rd_chk(3'h0, 8'h81);
        rd_chk(3'h0, 8'h7E);
        rd_chk(3'h5, 8'h60);
        fifo_enable <= 1'b0;
        far.push({1'b0, 1'b0, 1'b1, 8'h10});
        rd_chk(3'h5, 8'h65);
        rd_chk(3'h0, 8'h10);
    endtask : t_rx_overrun
    task automatic t_modem();
        far.set_modem(4'b0001);
        rd_chk(3'h6, 8'h11);
        rd_chk(3'h6, 8'h10);
        far.set_modem(4'b0101);
        rd_chk(3'h6, 8'h50);
        far.set_modem(4'b0001);
        rd_chk(3'h6, 8'h14);
        far.set_modem(4'b1011);
        rd_chk(3'h6, 8'hBA);
        rd_chk(3'h6, 8'hB0);
    endtask : t_modem
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        {wr_en, rd_en, addr, wr_data} = 13'h0000;
        fifo_enable = 1'b1;
        ce = 1'b1;
        tx_hold_empty = 1'b1;
        tx_shift_empty = 1'b1;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk({7'h00, rx_ready}, 8'h01);
        t_regs();
        t_divisor();
        t_rx_single();
        t_rx_overrun();
        t_modem();
        tally_and_finish();
    end
endmodule : tb_top

// file: tb/ulms_far_model.sv
`timescale 1ns/100ps
module ulms_far_model (
    input  wire logic               ref_clk,
    input  wire logic               rx_ready,
    output logic                    rx_valid,
    output ulms_pkg::ulms_rx_word_t rx_word,
    output ulms_pkg::ulms_modem_t   modem_in
);
    initial begin
        rx_valid = 1'b0;
        rx_word  = 11'h7FF;
        modem_in = 4'h0;
    end
    // offer a word, hold it until taken or for at most 50 cycles, then show the inverse
    task automatic push(input ulms_pkg::ulms_rx_word_t w);
        int n;
        n = 0;
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_word  <= w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!rx_ready && n < 50);
        rx_valid <= 1'b0;
        rx_word  <= ~w;
    endtask : push
    // offer a word for one cycle only, taken or not
    task automatic offer_once(input ulms_pkg::ulms_rx_word_t w);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_word  <= w;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_word  <= ~w;
    endtask : offer_once
    task automatic set_modem(input ulms_pkg::ulms_modem_t m);
        @(posedge ref_clk);
        modem_in <= m;
    endtask : set_modem
endmodule : ulms_far_model
